// File: hw/wrs_pkg.sv
// Shared constants and carrier types of the warm reset sequencer.
package wrs_pkg;

    // Clock rate and half clock period; one enable pulse per half period.
    localparam int unsigned MCLK_HZ        = 125000000;
    localparam int unsigned HCP_NS         = 16;
    localparam int unsigned MCLK_PERIOD_NS = 8;
    localparam int unsigned HCP_CYC        =
        (HCP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // Sequence lengths, counted in half clock periods.
    localparam logic [11:0] DETECT_HCP   = 12'h004;
    localparam logic [11:0] SETTLE_HCP   = 12'h00c;
    localparam logic [11:0] SEQ_HCP      = 12'h400;
    localparam logic [11:0] SAMPLE_HCP   = 12'h008;
    localparam logic [11:0] RELATCH_HCP  = 12'h003;

    // Configuration port fields.
    localparam int unsigned CLKOPT_HI    = 15;
    localparam int unsigned CLKOPT_LO    = 13;
    localparam int unsigned KEEP_HI      = 12;
    localparam int unsigned KEEP_LO      = 8;
    localparam int unsigned FORCE_HI     = 7;
    localparam int unsigned FORCE_LO     = 2;
    localparam logic [15:0] CFG_RESET    = 16'hffff;
    localparam logic [23:0] START_ADDR   = 24'h000000;

    // Reset source codes presented with the classification flags.
    typedef enum logic [1:0]
    {
        SRC_NONE = 2'h0,
        SRC_HW   = 2'h1,
        SRC_SW   = 2'h2,
        SRC_WDT  = 2'h3
    } wrs_src_t;

    // Classification handed to the watchdog status register.
    typedef struct packed
    {
        logic     shortFlag;
        logic     longFlag;
        wrs_src_t source;
    } wrs_flags_t;

    // Bus strobes driven inactive on leaving reset.
    typedef struct packed
    {
        logic aleStrobe;
        logic readStrobeN;
        logic writeLowStrobeN;
    } wrs_strobe_t;

endpackage : wrs_pkg

// File: hw/wrs_seq.sv
// Warm, software and watchdog reset sequencer.
// Function
// RULE1: Warm reset on low pin, select high.
// RULE2: Other side holds pin low 4 half-periods.
// RULE3: Tristate I/O, drive reset output low.
// RULE4: Cancel holds within 12, abort bus.
// RULE5: Pull reset pin down if bidir enabled.
// RULE6: Clear bidir enable on every reset.
// RULE7: Run 1024 half-period sequence after 16; code starts it after 12.
// RULE8: Sample filtered input 8 later: short/long.
// RULE9: Long reset: port 15:13 transparent till high+3.
// RULE10: Hold reset until pin high, flash done.
// RULE11: Latch config, strobes inactive on exit.
// RULE12: Restart at address zero, segment zero.
// RULE13: Pull select pin down while pin low.
// RULE14: Select low mid-reset switches to asynchronous.
// RULE15: Software/watchdog ignore select pin level.
// RULE16: Software reset instruction starts sequence.
// RULE17: Software reset relatches 12:8, sets 7:2.
// RULE18: Software bidir pulldown only if select high.
// RULE19: Watchdog overflow starts sequence.
// RULE20: Watchdog finishes bus cycle unless ready high.
// RULE21: Watchdog relatches 12:8, sets 7:2.
// RULE22: Watchdog bidir pulldown only if select high.
// RULE23: Reset output released after end-of-init.
// RULE24: Present short/long flags and source.
module wrs_seq
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // Pins and external circuitry
    input  wire logic                resetInN,
    input  wire logic                filteredResetIn,
    input  wire logic                asyncSelectPin,
    input  wire logic                extMemoryBootN,
    input  wire logic [15:0]         configPort,
    output logic                     resetInPullOe,
    output logic                     selectPullOe,
    output logic                     resetOutN,
    output logic                     ioHighZ,
    output wrs_pkg::wrs_strobe_t     strobes,
    // Core and bus controller
    input  wire logic                softResetInstr,
    input  wire logic                wdtOverflow,
    input  wire logic                endOfInitInstr,
    input  wire logic                setBidirEnable,
    input  wire logic                flashInitDone,
    input  wire logic                extCycleActive,
    input  wire logic                extCycleUsesReady,
    input  wire logic                readySampledN,
    input  wire logic                readySampleValid,
    output logic                     coreReset,
    output logic                     cancelHolds,
    output logic                     abortExtCycle,
    output logic                     asyncReset,
    output logic                     bidirResetEnable,
    output logic [15:0]              systemConfigReg,
    output logic                     clkOptTransparent,
    output logic [23:0]              startAddr,
    output wrs_pkg::wrs_flags_t      flags
);
    import wrs_pkg::*;

    typedef enum logic [6:0]
    {
        ST_RUN    = 7'h01,
        ST_SETTLE = 7'h02,
        ST_SEQ    = 7'h04,
        ST_SAMPLE = 7'h08,
        ST_LONG   = 7'h10,
        ST_EXIT   = 7'h20,
        ST_ASYNC  = 7'h40
    } wrs_state_t;

    wrs_state_t  state_ff;
    logic [2:0]  rinSync_ff;
    logic [2:0]  rfSync_ff;
    logic [2:0]  selSync_ff;
    logic        rinLow_ff;
    logic        rfHigh_ff;
    logic        selHigh_ff;
    logic [1:0]  hcpDiv_ff;
    logic        hcpTick;
    logic [11:0] cnt_ff;
    logic [11:0] lowCnt_ff;
    logic [11:0] hiCnt_ff;
    logic        softSrc_ff;
    logic        wdtWait_ff;
    logic        pullEn_ff;
    logic        initDone_ff;

    // Three-stage synchronisers; only stages two and three are compared.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rinSync_ff <= 3'h7;
            rfSync_ff  <= 3'h7;
            selSync_ff <= 3'h7;
            rinLow_ff  <= 1'b0;
            rfHigh_ff  <= 1'b1;
            selHigh_ff <= 1'b1;
        end
        else
        begin
            rinSync_ff <= {rinSync_ff[1:0], resetInN};
            rfSync_ff  <= {rfSync_ff[1:0], filteredResetIn};
            selSync_ff <= {selSync_ff[1:0], asyncSelectPin};
            if (rinSync_ff[1] == rinSync_ff[2])
                rinLow_ff <= ~rinSync_ff[2];
            if (rfSync_ff[1] == rfSync_ff[2])
                rfHigh_ff <= rfSync_ff[2];
            if (selSync_ff[1] == selSync_ff[2])
                selHigh_ff <= selSync_ff[2];
        end
    end

    // Half clock period enable.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            hcpDiv_ff <= 2'h0;
        else if (hcpDiv_ff == 2'(HCP_CYC - 1))
            hcpDiv_ff <= 2'h0;
        else
            hcpDiv_ff <= hcpDiv_ff + 2'h1;
    end
    assign hcpTick = (hcpDiv_ff == 2'(HCP_CYC - 1));

    // Low-time counter on the reset pin for detection.
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !rinLow_ff)
            lowCnt_ff <= 12'h000;
        else if (hcpTick && lowCnt_ff != DETECT_HCP)
            lowCnt_ff <= lowCnt_ff + 12'h001;
    end

    // High-time counter on the filtered input for closing the port.
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !rfHigh_ff)
            hiCnt_ff <= 12'h000;
        else if (hcpTick && hiCnt_ff != RELATCH_HCP)
            hiCnt_ff <= hiCnt_ff + 12'h001;
    end

    // A pin reset needs four half periods low before it counts.
    logic hwDetect;
    assign hwDetect = rinLow_ff && lowCnt_ff == DETECT_HCP; // see RULE2

    // Watchdog request waits for a ready-driven cycle to resolve.
    logic wdtGo;
    assign wdtGo = wdtWait_ff &&
        (!extCycleActive || !extCycleUsesReady ||
         readySampleValid); // see RULE20

    // Main sequence.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_ff   <= ST_RUN;
            cnt_ff     <= 12'h000;
            softSrc_ff <= 1'b0;
            wdtWait_ff <= 1'b0;
            flags      <= '{1'b0, 1'b0, SRC_NONE};
        end
        else
        begin
            if (hcpTick && state_ff != ST_RUN)
                cnt_ff <= cnt_ff + 12'h001;
            case (state_ff)
                ST_RUN:
                begin
                    if (wdtOverflow)
                        wdtWait_ff <= 1'b1; // see RULE19
                    if (hwDetect && selHigh_ff)
                    begin
                        state_ff   <= ST_SETTLE; // see RULE1
                        softSrc_ff <= 1'b0;
                        cnt_ff     <= 12'h000;
                        flags      <= '{1'b0, 1'b0, SRC_HW};
                    end
                    else if (softResetInstr || wdtGo)
                    begin
                        state_ff   <= ST_SETTLE; // see RULE16
                        softSrc_ff <= 1'b1;
                        wdtWait_ff <= 1'b0;
                        cnt_ff     <= 12'h000;
                        flags      <= '{1'b0, 1'b0,
                                        softResetInstr ? SRC_SW : SRC_WDT};
                    end
                end
                ST_SETTLE:
                    if (hcpTick && cnt_ff == SETTLE_HCP - 12'h001)
                    begin
                        state_ff <= ST_SEQ; // see RULE7
                        cnt_ff   <= 12'h000;
                    end
                ST_SEQ:
                    if (hcpTick && cnt_ff == SEQ_HCP - 12'h001)
                    begin
                        state_ff <= ST_SAMPLE; // see RULE7
                        cnt_ff   <= 12'h000;
                    end
                ST_SAMPLE:
                    if (hcpTick && cnt_ff == SAMPLE_HCP - 12'h001)
                    begin
                        flags.shortFlag <= 1'b1; // see RULE8
                        if (!rfHigh_ff)
                        begin
                            flags.longFlag <= 1'b1; // see RULE8
                            if (softSrc_ff)
                                flags.source <= SRC_HW;
                            state_ff <= ST_LONG;
                        end
                        else
                            state_ff <= ST_EXIT;
                    end
                ST_LONG:
                    if (hiCnt_ff == RELATCH_HCP)
                        state_ff <= ST_EXIT; // see RULE9
                ST_EXIT:
                    if (!rinLow_ff && (!extMemoryBootN || flashInitDone))
                        state_ff <= ST_RUN; // see RULE10
                ST_ASYNC:
                    if (!rinLow_ff)
                        state_ff <= ST_EXIT; // see RULE14
                default:
                    state_ff <= ST_RUN;
            endcase
            // Only a pin-started reset degrades; select is ignored otherwise.
            if (state_ff != ST_RUN && state_ff != ST_ASYNC &&
                !softSrc_ff && !selHigh_ff)
                state_ff <= ST_ASYNC; // see RULE14, RULE15
        end
    end

    // Bidirectional enable, set by software during init only.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            bidirResetEnable <= 1'b0;
        else if (state_ff != ST_RUN)
            bidirResetEnable <= 1'b0; // see RULE6
        else if (setBidirEnable && !initDone_ff)
            bidirResetEnable <= 1'b1;
    end

    // Pulldown enable is captured at start so clearing does not drop it.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pullEn_ff <= 1'b0;
        else if (state_ff == ST_RUN)
            pullEn_ff <= bidirResetEnable;
    end

    // Reset output and end-of-init tracking.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            initDone_ff <= 1'b0;
            resetOutN   <= 1'b0;
        end
        else if (state_ff != ST_RUN)
        begin
            initDone_ff <= 1'b0;
            resetOutN   <= 1'b0; // see RULE3
        end
        else if (endOfInitInstr)
        begin
            initDone_ff <= 1'b1;
            resetOutN   <= 1'b1; // see RULE23
        end
    end

    // Pin drivers and core controls.
    logic inSeq;
    assign inSeq = state_ff == ST_SETTLE || state_ff == ST_SEQ;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            resetInPullOe <= 1'b0;
            selectPullOe  <= 1'b0;
            ioHighZ       <= 1'b1;
            coreReset     <= 1'b1;
            cancelHolds   <= 1'b0;
            abortExtCycle <= 1'b0;
            asyncReset    <= 1'b0;
        end
        else
        begin
            resetInPullOe <= inSeq && pullEn_ff && selHigh_ff
                             && state_ff != ST_ASYNC; // see RULE5, RULE18, RULE22
            selectPullOe  <= rinLow_ff; // see RULE13
            ioHighZ       <= state_ff != ST_RUN; // see RULE3
            coreReset     <= state_ff != ST_RUN; // see RULE10
            cancelHolds   <= state_ff == ST_SETTLE; // see RULE4
            // A watchdog lets a cycle without ready, or one that saw ready
            // low, run to its end; pin and software resets always cut it.
            abortExtCycle <= state_ff == ST_SETTLE && extCycleActive &&
                             !(flags.source == SRC_WDT &&
                               (!extCycleUsesReady ||
                                !readySampledN)); // see RULE4, RULE20
            asyncReset    <= state_ff == ST_ASYNC; // see RULE14
        end
    end

    // Configuration latch, clock option window, start vector.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            systemConfigReg   <= CFG_RESET;
            clkOptTransparent <= 1'b0;
            startAddr         <= START_ADDR;
            strobes           <= '{1'b0, 1'b1, 1'b1};
        end
        else
        begin
            clkOptTransparent <= state_ff == ST_LONG; // see RULE9
            if (state_ff == ST_EXIT && !rinLow_ff &&
                (!extMemoryBootN || flashInitDone))
            begin
                startAddr <= START_ADDR; // see RULE12
                strobes   <= '{1'b0, 1'b1, 1'b1}; // see RULE11
                if (softSrc_ff && !flags.longFlag)
                begin
                    systemConfigReg[KEEP_HI:KEEP_LO] <=
                        configPort[KEEP_HI:KEEP_LO]; // see RULE17, RULE21
                    systemConfigReg[FORCE_HI:FORCE_LO] <= '1;
                end
                else
                    systemConfigReg[KEEP_HI:0] <=
                        configPort[KEEP_HI:0]; // see RULE11
            end
            if (state_ff == ST_LONG)
                systemConfigReg[CLKOPT_HI:CLKOPT_LO] <=
                    configPort[CLKOPT_HI:CLKOPT_LO]; // see RULE9
        end
    end

    // Flags handed onward as a packed group.  see RULE24

    a_seq_length: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(state_ff == ST_SAMPLE) |-> $past(state_ff) == ST_SEQ) // see RULE7
        else $error("sample phase entered from wrong state");
    a_out_low_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        state_ff == ST_SEQ |=> !resetOutN) // see RULE3
        else $error("reset output high during sequence");
    a_bidir_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        state_ff == ST_SEQ |=> !bidirResetEnable) // see RULE6
        else $error("bidir enable not cleared");
    a_pull_select: assert property (@(posedge mclk) disable iff (!rst_n)
        resetInPullOe |-> $past(selHigh_ff)) // see RULE18
        else $error("pulldown with select low");
    a_long_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(flags.longFlag) |-> flags.shortFlag) // see RULE8
        else $error("long flag without short flag");
    a_window_close: assert property (@(posedge mclk) disable iff (!rst_n)
        state_ff == ST_LONG ##1 state_ff == ST_EXIT |->
        ##1 !clkOptTransparent) // see RULE9
        else $error("clock option window stays open");
    a_sel_pull: assert property (@(posedge mclk) disable iff (!rst_n)
        rinLow_ff |=> selectPullOe) // see RULE13
        else $error("select pulldown missing");
    a_stay_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        state_ff == ST_EXIT && rinLow_ff |=> state_ff != ST_RUN) // see RULE10
        else $error("left reset with pin low");
    a_settle_time: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(state_ff == ST_SETTLE) |-> ##[1:30] state_ff != ST_SETTLE) // see RULE4
        else $error("settle phase too long");

endmodule : wrs_seq

// File: tb/wrs_ext_reset.sv
// Model of the external reset circuitry driving the reset input pin.
module wrs_ext_reset
#(
    parameter int unsigned MIN_HOLD = 8,
    parameter int unsigned FILT_CYC = 4
)
(
    // Clock
    input  wire logic        mclk,
    // Requests from the bench
    input  wire logic        pulseGo,
    input  wire logic [15:0] holdCyc,
    // Device side of the pin
    input  wire logic        pullOe,
    output logic             pinN,
    output logic             filtN
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0]         lowCnt_ff = 16'h0000;
    logic [FILT_CYC-1:0] filt_ff   = '1;

    // A pulse below four half periods would never be detected, so the
    // circuitry stretches any shorter request to that minimum.
    always_ff @(posedge mclk)
    begin
        if (pulseGo)
            lowCnt_ff <= (holdCyc < MIN_HOLD) ? 16'(MIN_HOLD) : holdCyc;
        else if (lowCnt_ff != 16'h0000)
            lowCnt_ff <= lowCnt_ff - 16'h0001;
    end

    // Open-drain line with a pull-up; the filter lags the pin level.
    assign pinN = !((lowCnt_ff != 16'h0000) || pullOe);

    always_ff @(posedge mclk)
    begin
        filt_ff <= {filt_ff[FILT_CYC-2:0], pinN};
    end

    assign filtN = filt_ff[FILT_CYC-1];
endmodule : wrs_ext_reset

// File: tb/wrs_seq_tb.sv
// Self-checking bench of the warm reset sequencer.
module wrs_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wrs_pkg::*;

    typedef struct packed
    {
        logic [1:0]  kind;
        logic [15:0] lowCyc;
        logic        sel;
        logic        bidir;
        logic        ext;
        logic [15:0] cfg;
        wrs_flags_t  expFlags;
    } wrs_row_t;

    localparam int NROWS = 7;
    // Kind 0 is a pin reset, 1 software, 2 watchdog.
    wrs_row_t rows [NROWS] = '{
        '{2'h0, 16'd20, 1'b1, 1'b0, 1'b1, 16'h5a3c, '{1'b1, 1'b0, SRC_HW}},
        '{2'h0, 16'd2400, 1'b1, 1'b0, 1'b1, 16'ha5c3, '{1'b1, 1'b1, SRC_HW}},
        '{2'h1, 16'd0, 1'b0, 1'b0, 1'b1, 16'h1e00, '{1'b1, 1'b0, SRC_SW}},
        '{2'h1, 16'd0, 1'b1, 1'b1, 1'b1, 16'h0f0f, '{1'b1, 1'b0, SRC_SW}},
        '{2'h1, 16'd0, 1'b0, 1'b1, 1'b1, 16'h3300, '{1'b1, 1'b0, SRC_SW}},
        '{2'h2, 16'd0, 1'b1, 1'b1, 1'b0, 16'hc0de, '{1'b1, 1'b0, SRC_WDT}},
        '{2'h2, 16'd0, 1'b0, 1'b0, 1'b0, 16'h7777, '{1'b1, 1'b0, SRC_WDT}}
    };

    logic mclk, rst_n, resetInN, filteredResetIn, asyncSelectPin;
    logic extMemoryBootN, softResetInstr, wdtOverflow, endOfInitInstr;
    logic setBidirEnable, flashInitDone, extCycleActive, extCycleUsesReady;
    logic readySampledN, readySampleValid, resetInPullOe, selectPullOe;
    logic resetOutN, ioHighZ, coreReset, cancelHolds, abortExtCycle;
    logic asyncReset, bidirResetEnable, clkOptTransparent, extGo;
    logic [15:0] configPort, systemConfigReg, extHold, cfgModel;
    logic [23:0] startAddr;
    wrs_strobe_t strobes;
    wrs_flags_t  flags;
    logic sawAbort, sawCancel, sawPull, sawTrans, sawHighZ, sawSelPull;
    int errTotal = 0;
    int totalChecks = 0;
    int cycCount = 0;

    wrs_seq u_dut (.mclk(mclk), .rst_n(rst_n), .resetInN(resetInN),
        .filteredResetIn(filteredResetIn), .asyncSelectPin(asyncSelectPin),
        .extMemoryBootN(extMemoryBootN), .configPort(configPort),
        .resetInPullOe(resetInPullOe), .selectPullOe(selectPullOe),
        .resetOutN(resetOutN), .ioHighZ(ioHighZ), .strobes(strobes),
        .softResetInstr(softResetInstr), .wdtOverflow(wdtOverflow),
        .endOfInitInstr(endOfInitInstr), .setBidirEnable(setBidirEnable),
        .flashInitDone(flashInitDone), .extCycleActive(extCycleActive),
        .extCycleUsesReady(extCycleUsesReady), .readySampledN(readySampledN),
        .readySampleValid(readySampleValid), .coreReset(coreReset),
        .cancelHolds(cancelHolds), .abortExtCycle(abortExtCycle),
        .asyncReset(asyncReset), .bidirResetEnable(bidirResetEnable),
        .systemConfigReg(systemConfigReg),
        .clkOptTransparent(clkOptTransparent), .startAddr(startAddr),
        .flags(flags));

    wrs_ext_reset u_ext (.mclk(mclk), .pulseGo(extGo), .holdCyc(extHold),
        .pullOe(resetInPullOe), .pinN(resetInN), .filtN(filteredResetIn));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finishTest();
        if (errTotal == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finishTest

    // Outputs are sampled mid-cycle; the task returns on a rising edge.
    task automatic tick();
        @(negedge mclk);
        sawAbort   |= abortExtCycle;
        sawCancel  |= cancelHolds;
        sawPull    |= resetInPullOe;
        sawTrans   |= clkOptTransparent;
        sawHighZ   |= ioHighZ;
        sawSelPull |= selectPullOe;
        @(posedge mclk);
    endtask : tick

    task automatic end_of_init_instr();
        endOfInitInstr <= 1'b1;
        tick();
        endOfInitInstr <= 1'b0;
        repeat (4) tick();
        check(resetOutN, 1'b1);
        {sawAbort, sawCancel, sawPull, sawTrans, sawHighZ, sawSelPull} = '0;
    endtask : end_of_init_instr

    task automatic startReset(input logic [1:0] kind, input logic [15:0] n);
        extGo          <= (kind == 2'h0);
        extHold        <= n;
        softResetInstr <= (kind == 2'h1);
        wdtOverflow    <= (kind == 2'h2);
        tick();
        {extGo, softResetInstr, wdtOverflow} <= 3'b000;
    endtask : startReset

    // The full sequence is over within 2500 cycles, the long pin reset included; the flash keeps
    // the core in reset until its initialization is reported done.
    task automatic waitExit();
        int n;
        repeat (2500) tick();
        check(coreReset, 1'b1);
        flashInitDone <= 1'b1;
        for (n = 0; n < 40 && coreReset !== 1'b0; n++)
            tick();
        check(coreReset, 1'b0);
    endtask : waitExit

    task automatic runRow(input wrs_row_t r);
        {configPort, asyncSelectPin, extCycleActive} <= {r.cfg, r.sel, r.ext};
        {extCycleUsesReady, readySampleValid, flashInitDone} <= 3'b000;
        if (r.bidir)
        begin
            setBidirEnable <= 1'b1;
            tick();
            setBidirEnable <= 1'b0;
            repeat (2) tick();
            check(bidirResetEnable, 1'b1);
        end
        end_of_init_instr();
        startReset(r.kind, r.lowCyc);
        waitExit();
        if (r.kind == 2'h0)
            cfgModel = r.expFlags.longFlag ? r.cfg
                                           : {cfgModel[15:13], r.cfg[12:0]};
        else
            cfgModel = {cfgModel[15:13], r.cfg[12:8], 6'h3f, cfgModel[1:0]};
        check(flags, r.expFlags);
        check(systemConfigReg, cfgModel);
        check(strobes, 3'b011);
        check(startAddr, 24'h000000);
        check(resetOutN, 1'b0);
        check(sawHighZ, 1'b1);
        check(sawCancel, 1'b1);
        check(sawAbort, r.ext & (r.kind != 2'h2));
        check(sawPull, r.bidir & r.sel);
        check(sawSelPull, (r.kind == 2'h0) | (r.bidir & r.sel));
        check(sawTrans, r.expFlags.longFlag);
        check(clkOptTransparent, 1'b0);
        check(bidirResetEnable, 1'b0);
    endtask : runRow

    always @(posedge mclk)
    begin
        cycCount++;
        if (cycCount == 40000)
        begin
            errTotal++;
            finishTest();
        end
    end

    initial
    begin
        {rst_n, extGo, softResetInstr, wdtOverflow, endOfInitInstr} <= '0;
        {setBidirEnable, flashInitDone, extCycleActive} <= '0;
        {extCycleUsesReady, readySampleValid} <= '0;
        {asyncSelectPin, extMemoryBootN, readySampledN} <= 3'b111;
        {configPort, extHold, cfgModel} <= {16'h0000, 16'h0000, CFG_RESET};
        repeat (20) tick();
        check(coreReset, 1'b1);
        check(systemConfigReg, CFG_RESET);
        rst_n <= 1'b1;
        tick();
        check(resetOutN, 1'b0);
        check(bidirResetEnable, 1'b0);
        check(flags, 4'h0);
        for (int i = 0; i < NROWS; i++)
            runRow(rows[i]);
        // Select pin falls mid-sequence, then recovers: stays asynchronous.
        {configPort, extCycleActive, flashInitDone} <= {16'h4321, 2'b00};
        asyncSelectPin <= 1'b1;
        end_of_init_instr();
        startReset(2'h0, 16'd2400);
        repeat (100) tick();
        asyncSelectPin <= 1'b0;
        repeat (10) tick();
        check(asyncReset, 1'b1);
        asyncSelectPin <= 1'b1;
        repeat (10) tick();
        check(asyncReset, 1'b1);
        waitExit();
        // Watchdog waits for the ready sample, then aborts on ready high.
        {extCycleActive, extCycleUsesReady, flashInitDone} <= 3'b110;
        {readySampleValid, readySampledN} <= 2'b01;
        end_of_init_instr();
        startReset(2'h2, 16'd0);
        repeat (20) tick();
        check(coreReset, 1'b0);
        readySampleValid <= 1'b1;
        repeat (4) tick();
        check(sawAbort, 1'b1);
        {extCycleActive, readySampleValid} <= 2'b00;
        waitExit();
        check(flags, wrs_flags_t'{1'b1, 1'b0, SRC_WDT});
        finishTest();
    end
endmodule : wrs_seq_tb
